// ==== qcp_enc_model.sv ====
// Encoder and pulse source model driving the digital inputs
`timescale 1ns/10ps
module qcp_enc_model #(
   parameter int P_EDGE_CYC = 250
) (
   input  wire logic       i_sys_clk,
   output logic [3:0]      o_din
);
   initial o_din = 4'h0;

   // One full cycle, four edges 251 clocks apart: just under 10 kHz
   task automatic quad(input int ch, input logic fwd);
      logic a;
      logic b;
      for (int e = 0; e < 4; e++) begin
         a = o_din[2*ch];
         b = o_din[2*ch+1];
         @(posedge i_sys_clk);
         if ((a == b) == fwd) o_din[2*ch] <= ~a;
         else o_din[2*ch+1] <= ~b;
         repeat (P_EDGE_CYC) @(posedge i_sys_clk);
      end
   endtask

   // Single-pin train; caller keeps hi+lo at or above 1000 clocks
   task automatic pulse(input int b, input int hi, input int lo, input int n);
      @(posedge i_sys_clk);
      for (int k = 0; k < n; k++) begin
         o_din[b] <= 1'b1;
         repeat (hi) @(posedge i_sys_clk);
         o_din[b] <= 1'b0;
         repeat (lo) @(posedge i_sys_clk);
      end
   endtask
endmodule

// ==== qcp_pkg.sv ====
// Package: register map, decode modes, timing and carriers for the counter block
package qcp_pkg;
   localparam int CLK_HZ      = 10_000_000;
   localparam int CLK_NS      = 100;
   localparam int US_NS       = 1000;
   localparam int GATE_MS     = 1000;
   localparam int US_CYC      = US_NS / CLK_NS;
   localparam int GATE_CYC    = GATE_MS * (CLK_HZ / 1000);

   localparam logic [11:0] A_CNT_EN  = 12'h000;
   localparam logic [11:0] A_PM_EN   = 12'h004;
   localparam logic [11:0] A_DECODE  = 12'h008;
   localparam logic [11:0] A_RESOL   = 12'h00C;
   localparam logic [11:0] A_OPTION  = 12'h010;
   localparam logic [11:0] A_STATUS  = 12'h014;
   localparam logic [11:0] A_COUNT   = 12'h018;
   localparam logic [11:0] A_TARGET  = 12'h020;
   localparam logic [11:0] A_WIDTH   = 12'h028;
   localparam logic [11:0] A_PERIOD  = 12'h038;
   localparam logic [11:0] A_FREQ    = 12'h048;
   localparam logic [11:0] A_STRIDE  = 12'h004;

   localparam logic [7:0]  RES_SIMPLE = 8'h00;
   localparam logic [7:0]  RES_X1     = 8'h01;
   localparam logic [7:0]  RES_X2     = 8'h02;
   localparam logic [7:0]  RES_X4     = 8'h03;
   localparam logic [7:0]  RES_CH1    = 8'h01;
   localparam int          OPT_TENTH  = 0;
   localparam int          STAT_IN    = 4;

   typedef enum logic [2:0] {
      MODE_SIMPLE = 3'b000,
      MODE_ENH    = 3'b001,
      MODE_X1     = 3'b010,
      MODE_X2     = 3'b011,
      MODE_X4     = 3'b100
   } qcp_mode_e;

   typedef struct packed {
      logic [31:0] width;
      logic [31:0] period;
      logic [31:0] freq;
   } qcp_pm_s;
endpackage

// ==== qcp_quad_ch.sv ====
// Module: one quadrature counter channel with decode modes and target match
`timescale 1ns/10ps
module qcp_quad_ch (
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_phase_a,
   input  wire logic                i_phase_b,
   input  wire logic                i_enable,
   input  wire qcp_pkg::qcp_mode_e  i_mode,
   input  wire logic                i_load,
   input  wire logic [31:0]         i_load_val,
   input  wire logic [31:0]         i_target,
   output logic [31:0]              o_count,
   output logic                     o_match
);
   logic [1:0]  prev_q;
   logic [1:0]  cur;
   logic        fwd;
   logic        rev;
   logic        a_chg;
   logic        up;
   logic        dn;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic        match_q;

   // Forward successor of a phase pair {a,b}
   function automatic logic [1:0] gray_next(input logic [1:0] p);
      case (p)
         2'b00:   gray_next = 2'b10;
         2'b10:   gray_next = 2'b11;
         2'b11:   gray_next = 2'b01;
         default: gray_next = 2'b00;
      endcase
   endfunction

   assign cur   = {i_phase_a, i_phase_b};
   assign fwd   = cur == gray_next(prev_q);
   assign rev   = prev_q == gray_next(cur);
   assign a_chg = prev_q[1] ^ cur[1];

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         prev_q <= 2'h0;
      end else begin
         prev_q <= cur;
      end
   end

   always_comb begin
      up = 1'b0;
      dn = 1'b0;
      case (i_mode)
         qcp_pkg::MODE_SIMPLE: begin
            // Either phase alone still counts; vibration can double count
            up = ~prev_q[1] & cur[1] & ~cur[0];
            dn = ~prev_q[0] & cur[0] & ~cur[1];
         end
         qcp_pkg::MODE_ENH, qcp_pkg::MODE_X1: begin
            // A jiggle back over the edge undoes the count it made
            up = fwd & (prev_q == 2'b00);
            dn = rev & (cur == 2'b00);
         end
         qcp_pkg::MODE_X2: begin
            up = fwd & a_chg;
            dn = rev & a_chg;
         end
         qcp_pkg::MODE_X4: begin
            up = fwd;
            dn = rev;
         end
         default: begin
            up = 1'b0;
            dn = 1'b0;
         end
      endcase
   end

   always_comb begin
      cnt_d = i_load ? i_load_val : cnt_q;
      // Load and step merge so no edge is lost during an access
      if (i_enable && up) begin
         cnt_d = cnt_d + 32'h1;
      end else if (i_enable && dn) begin
         cnt_d = cnt_d - 32'h1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cnt_q   <= 32'h0;
         match_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         match_q <= i_enable & (up | dn) & (cnt_d == i_target);
      end
   end

   assign o_count = cnt_q;
   assign o_match = match_q;

   count_up_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_enable && up && !i_load) |=> o_count == $past(o_count) + 32'h1)
      else $error("count did not step up");
   count_dn_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_enable && dn && !i_load) |=> o_count == $past(o_count) - 32'h1)
      else $error("count did not step down");
   single_phase_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_enable && !i_load && i_mode == qcp_pkg::MODE_SIMPLE && !i_phase_b
       && $rose(i_phase_a)) |=> o_count == $past(o_count) + 32'h1)
      else $error("single phase pulse not counted");
   x1_hold_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_mode == qcp_pkg::MODE_X1 && !i_load && prev_q == 2'b10 && cur == 2'b11)
      |=> o_count == $past(o_count))
      else $error("x1 counted a mid cycle edge");
   load_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_load && !up && !dn) |=> o_count == $past(i_load_val))
      else $error("count load lost");
   match_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_match |-> o_count == $past(i_target))
      else $error("match without target value");
endmodule

// ==== qcp_top.sv ====
// Module: APB top of the quadrature counter and pulse meter block
// Function
// - Two counter channels, phases on inputs 3/4 and 5/6.
// - A leading B counts up one per pulse, lagging counts down.
// - Simple mode: A pulses with B off up, B pulses with A off down.
// - Simple mode works as a single-phase pulse counter.
// - Count reaching target raises an event; target reloadable afterwards.
// - Enabling a counter also enables pulse measurement on its pins.
// - Decode word bit 0/1 picks simple or enhanced per channel.
// - Enhanced decoding checks both phases to block vibration recounts.
// - Default counts one per full quadrature cycle.
// - x2 counts every two edges, x4 every edge.
// - Resolution word: upper byte channel, lower byte simple/x1/x2/x4.
// - Resolution write overrides earlier decode word for that channel.
// - Four meters on inputs 3 to 6 give width, period, frequency.
// - Width and period in microseconds, frequency in hertz by default.
// - Global option reports width and period in 0.1 us.
// - Meter enable alone never enables a counter.
// - Meter enable on an active counter's pins disables that counter.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
module qcp_top #(
   parameter int P_GATE_CYC = qcp_pkg::GATE_CYC
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic [3:0]  i_din,
   output logic [1:0]       o_match
);
   logic [3:0]          meta_q;
   logic [3:0]          din_q;
   logic                wr_en;
   logic                setup;
   logic [31:0]         rdata_d;
   logic                known;
   logic [31:0]         prdata_q;
   logic                slverr_q;
   logic [1:0]          cnt_en_q;
   logic [3:0]          pm_en_q;
   logic [3:0]          pm_act;
   logic                tenth_q;
   logic [1:0]          flag_q;
   logic [1:0]          clr;
   logic [1:0]          match;
   logic [1:0]          load;
   logic [31:0]         count    [2];
   logic [31:0]         target_q [2];
   qcp_pkg::qcp_mode_e  mode_q   [2];
   qcp_pkg::qcp_pm_s    pm_res   [4];
   logic [31:0]         gate_q;
   logic                gate_end;

   function automatic logic [11:0] at(input logic [11:0] base, input int k);
      at = base + 12'(k) * qcp_pkg::A_STRIDE;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = a == off;
   endfunction

   // Unknown resolution codes leave the mode as it was
   function automatic qcp_pkg::qcp_mode_e res_mode(input logic [7:0] c,
                                                   input qcp_pkg::qcp_mode_e old);
      case (c)
         qcp_pkg::RES_SIMPLE: res_mode = qcp_pkg::MODE_SIMPLE;
         qcp_pkg::RES_X1:     res_mode = qcp_pkg::MODE_X1;
         qcp_pkg::RES_X2:     res_mode = qcp_pkg::MODE_X2;
         qcp_pkg::RES_X4:     res_mode = qcp_pkg::MODE_X4;
         default:             res_mode = old;
      endcase
   endfunction

   // Encoder edges are asynchronous to the system clock
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         meta_q <= 4'h0;
         din_q  <= 4'h0;
      end else begin
         meta_q <= i_din;
         din_q  <= meta_q;
      end
   end

   assign wr_en = i_psel & i_penable & i_pwrite;
   assign setup = i_psel & ~i_penable;

   always_comb begin
      rdata_d = 32'h0;
      known   = 1'b1;
      case (i_paddr)
         qcp_pkg::A_CNT_EN: rdata_d = {30'h0, cnt_en_q};
         qcp_pkg::A_PM_EN:  rdata_d = {28'h0, pm_act};
         qcp_pkg::A_DECODE: rdata_d = {26'h0, mode_q[1], mode_q[0]};
         qcp_pkg::A_RESOL:  rdata_d = {26'h0, mode_q[1], mode_q[0]};
         qcp_pkg::A_OPTION: rdata_d = {31'h0, tenth_q};
         qcp_pkg::A_STATUS: rdata_d = {24'h0, din_q, 2'h0, flag_q};
         default:           known   = 1'b0;
      endcase
      for (int k = 0; k < 2; k++) begin
         if (hit(i_paddr, at(qcp_pkg::A_COUNT, k))) begin
            rdata_d = count[k];
            known   = 1'b1;
         end
         if (hit(i_paddr, at(qcp_pkg::A_TARGET, k))) begin
            rdata_d = target_q[k];
            known   = 1'b1;
         end
      end
      for (int k = 0; k < 4; k++) begin
         if (hit(i_paddr, at(qcp_pkg::A_WIDTH, k))) begin
            rdata_d = pm_res[k].width;
            known   = 1'b1;
         end
         if (hit(i_paddr, at(qcp_pkg::A_PERIOD, k))) begin
            rdata_d = pm_res[k].period;
            known   = 1'b1;
         end
         if (hit(i_paddr, at(qcp_pkg::A_FREQ, k))) begin
            rdata_d = pm_res[k].freq;
            known   = 1'b1;
         end
      end
   end

   // Read data is captured in the setup phase so access has no wait state
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         prdata_q <= 32'h0;
         slverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= i_pwrite ? 32'h0 : rdata_d;
         slverr_q <= ~known;
      end
   end

   assign o_pready  = 1'b1;
   assign o_prdata  = prdata_q;
   assign o_pslverr = slverr_q & i_psel & i_penable;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cnt_en_q <= 2'h0;
      end else if (wr_en && hit(i_paddr, qcp_pkg::A_CNT_EN)) begin
         cnt_en_q <= i_pwdata[1:0];
      end else if (wr_en && hit(i_paddr, qcp_pkg::A_PM_EN)) begin
         // Only clears, so a meter write never starts a counter
         cnt_en_q <= cnt_en_q & ~{|i_pwdata[3:2], |i_pwdata[1:0]};
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         pm_en_q <= 4'h0;
      end else if (wr_en && hit(i_paddr, qcp_pkg::A_PM_EN)) begin
         pm_en_q <= i_pwdata[3:0];
      end
   end

   assign pm_act = pm_en_q | {{2{cnt_en_q[1]}}, {2{cnt_en_q[0]}}};

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         mode_q[0] <= qcp_pkg::MODE_SIMPLE;
         mode_q[1] <= qcp_pkg::MODE_SIMPLE;
      end else if (wr_en && hit(i_paddr, qcp_pkg::A_DECODE)) begin
         for (int k = 0; k < 2; k++) begin
            mode_q[k] <= i_pwdata[k] ? qcp_pkg::MODE_ENH : qcp_pkg::MODE_SIMPLE;
         end
      end else if (wr_en && hit(i_paddr, qcp_pkg::A_RESOL)) begin
         for (int k = 0; k < 2; k++) begin
            if (i_pwdata[15:8] == qcp_pkg::RES_CH1 + 8'(k)) begin
               mode_q[k] <= res_mode(i_pwdata[7:0], mode_q[k]);
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         tenth_q <= 1'b0;
      end else if (wr_en && hit(i_paddr, qcp_pkg::A_OPTION)) begin
         tenth_q <= i_pwdata[qcp_pkg::OPT_TENTH];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         target_q[0] <= 32'h0;
         target_q[1] <= 32'h0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (wr_en && hit(i_paddr, at(qcp_pkg::A_TARGET, k))) begin
               target_q[k] <= i_pwdata;
            end
         end
      end
   end

   assign clr = (wr_en && hit(i_paddr, qcp_pkg::A_STATUS)) ? i_pwdata[1:0] : 2'h0;

   // A match in the clearing cycle survives the clear
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         flag_q <= 2'h0;
      end else begin
         flag_q <= match | (flag_q & ~clr);
      end
   end

   assign o_match = match;

   for (genvar c = 0; c < 2; c++) begin : g_qc
      assign load[c] = wr_en & hit(i_paddr, at(qcp_pkg::A_COUNT, c));
      qcp_quad_ch u_ch (
         .i_sys_clk  (i_sys_clk),
         .i_rst_n    (i_rst_n),
         .i_phase_a  (din_q[2*c]),
         .i_phase_b  (din_q[2*c+1]),
         .i_enable   (cnt_en_q[c]),
         .i_mode     (mode_q[c]),
         .i_load     (load[c]),
         .i_load_val (i_pwdata),
         .i_target   (target_q[c]),
         .o_count    (count[c]),
         .o_match    (match[c])
      );
   end

   // Frequency uses a one second gate shared by all meters
   assign gate_end = gate_q == 32'(P_GATE_CYC - 1);

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || gate_end) begin
         gate_q <= 32'h0;
      end else begin
         gate_q <= gate_q + 32'h1;
      end
   end

   for (genvar k = 0; k < 4; k++) begin : g_pm
      logic        prev_q;
      logic        seen_q;
      logic        rise;
      logic        fall;
      logic [3:0]  sub_q;
      logic [31:0] tcnt_q;
      logic [31:0] ucnt_q;
      logic [31:0] ecnt_q;
      logic [31:0] width_q;
      logic [31:0] period_q;
      logic [31:0] freq_q;

      assign rise = pm_act[k] & din_q[k] & ~prev_q;
      assign fall = pm_act[k] & ~din_q[k] & prev_q;

      // One cycle is one 0.1 us tick; the rise cycle is the first tick
      always_ff @(posedge i_sys_clk) begin
         if (!i_rst_n || rise) begin
            tcnt_q <= 32'h1;
            ucnt_q <= 32'h0;
            sub_q  <= 4'h1;
         end else begin
            tcnt_q <= tcnt_q + 32'h1;
            sub_q  <= (sub_q == 4'(qcp_pkg::US_CYC - 1)) ? 4'h0 : sub_q + 4'h1;
            if (sub_q == 4'(qcp_pkg::US_CYC - 1)) begin
               ucnt_q <= ucnt_q + 32'h1;
            end
         end
      end

      always_ff @(posedge i_sys_clk) begin
         if (!i_rst_n) begin
            prev_q   <= 1'b0;
            seen_q   <= 1'b0;
            width_q  <= 32'h0;
            period_q <= 32'h0;
         end else begin
            prev_q <= din_q[k];
            seen_q <= pm_act[k] & (seen_q | rise);
            if (fall && seen_q) begin
               width_q <= tenth_q ? tcnt_q : ucnt_q;
            end
            if (rise && seen_q) begin
               period_q <= tenth_q ? tcnt_q : ucnt_q;
            end
         end
      end

      always_ff @(posedge i_sys_clk) begin
         if (!i_rst_n) begin
            ecnt_q <= 32'h0;
            freq_q <= 32'h0;
         end else if (gate_end) begin
            ecnt_q <= 32'h0;
            freq_q <= ecnt_q + {31'h0, rise};
         end else if (rise) begin
            ecnt_q <= ecnt_q + 32'h1;
         end
      end

      assign pm_res[k] = '{width: width_q, period: period_q, freq: freq_q};
   end

   sync_path_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      ($past(i_rst_n) && $past(i_rst_n, 2)) |-> din_q == $past(i_din, 2))
      else $error("input not delayed by two stages");
   pm_kills_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (wr_en && hit(i_paddr, qcp_pkg::A_PM_EN) && i_pwdata[2]) |=> !cnt_en_q[1])
      else $error("meter enable left counter on");
   pm_only_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (wr_en && hit(i_paddr, qcp_pkg::A_PM_EN)) |=> (cnt_en_q & ~$past(cnt_en_q)) == 2'h0)
      else $error("meter enable started a counter");
   decode_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (wr_en && hit(i_paddr, qcp_pkg::A_DECODE)) |=>
      mode_q[1] == ($past(i_pwdata[1]) ? qcp_pkg::MODE_ENH : qcp_pkg::MODE_SIMPLE))
      else $error("decode word not applied");
   resol_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (wr_en && hit(i_paddr, qcp_pkg::A_RESOL)
       && i_pwdata[15:0] == {qcp_pkg::RES_CH1, qcp_pkg::RES_X2})
      |=> mode_q[0] == qcp_pkg::MODE_X2 && mode_q[1] == $past(mode_q[1]))
      else $error("resolution word not applied");
   flag_set_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      match[0] |=> flag_q[0])
      else $error("match event lost");
   width_unit_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (g_pm[2].fall && g_pm[2].seen_q && tenth_q) |=> pm_res[2].width == $past(g_pm[2].tcnt_q))
      else $error("width not in tenths");
   meter_on_a : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(cnt_en_q[0]) |-> pm_act[1:0] == 2'h3 ##1 pm_act[1:0] == 2'h3 || !cnt_en_q[0])
      else $error("counter pins not measured");
endmodule

// ==== tb_quadrature_counter_pulse_measure.sv ====
// Self-checking bench for the quadrature counter and pulse meter block
`timescale 1ns/10ps
module tb_quadrature_counter_pulse_measure;
   localparam int GATE = 2000;
   localparam int PER  = 1000;
   logic        i_sys_clk = 1'b0;
   logic        i_rst_n   = 1'b0;
   logic        i_psel    = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite  = 1'b0;
   logic [11:0] i_paddr   = 12'h000;
   logic [31:0] i_pwdata  = 32'h0;
   logic [31:0] o_prdata;
   logic        o_pready;
   logic        o_pslverr;
   logic [3:0]  i_din;
   logic [1:0]  o_match;
   logic [31:0] d;
   logic        e;
   int          bad_count   = 0;
   int          comparisons = 0;
   int          cyc         = 0;
   int          match_seen  = 0;

   qcp_top #(.P_GATE_CYC(GATE)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_din(i_din), .o_match(o_match));
   qcp_enc_model enc (.i_sys_clk(i_sys_clk), .o_din(i_din));

   always #50 i_sys_clk = ~i_sys_clk;

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Run is about 28k cycles; ceiling leaves margin
   always @(posedge i_sys_clk) begin
      cyc++;
      if (o_match[0] === 1'b1) match_seen++;
      if (cyc == 60000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Zero-wait slave, but still wait for pready at an access edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
      @(posedge i_sys_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_sys_clk);
      i_penable <= 1'b1;
      @(posedge i_sys_clk);
      while (o_pready !== 1'b1) @(posedge i_sys_clk);
      rdat = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, d, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] rdat);
      apb(1'b0, a, 32'h0, rdat, e);
   endtask

   task automatic t_reset;
      rd(qcp_pkg::A_CNT_EN, d);
      chk(d, 32'h0);
      apb(1'b0, 12'hFFC, 32'h0, d, e);
      chk({31'h0, e}, 32'h1);
      chk(d, 32'h0);
   endtask

   task automatic t_modes;
      logic [7:0] res [3];
      int         ex  [3];
      res = '{qcp_pkg::RES_X1, qcp_pkg::RES_X2, qcp_pkg::RES_X4};
      ex = '{1, 2, 4};
      wr(qcp_pkg::A_CNT_EN, 32'h3);
      for (int ch = 0; ch < 2; ch++) begin
         for (int i = 0; i < 3; i++) begin
            wr(qcp_pkg::A_RESOL, {16'h0, 8'(ch + 1), res[i]});
            wr(qcp_pkg::A_COUNT + 12'(4 * ch), 32'h0);
            enc.quad(ch, 1'b1);
            rd(qcp_pkg::A_COUNT + 12'(4 * ch), d);
            chk(d, 32'(ex[i]));
            enc.quad(ch, 1'b0);
            rd(qcp_pkg::A_COUNT + 12'(4 * ch), d);
            chk(d, 32'h0);
            rd(qcp_pkg::A_DECODE, d);
            chk(d, (ch == 0) ? 32'(i + 2) : 32'(4 + ((i + 2) << 3)));
         end
      end
   endtask

   task automatic t_decode;
      wr(qcp_pkg::A_DECODE, 32'h2);
      rd(qcp_pkg::A_DECODE, d);
      chk(d, 32'h08);
      wr(qcp_pkg::A_RESOL, 32'h0203);
      rd(qcp_pkg::A_DECODE, d);
      chk(d, 32'h20);
      wr(qcp_pkg::A_DECODE, 32'h1);
      wr(qcp_pkg::A_COUNT, 32'h0);
      // Jiggle on A alone must cancel out in enhanced mode
      enc.pulse(0, 250, 750, 3);
      rd(qcp_pkg::A_COUNT, d);
      chk(d, 32'h0);
   endtask

   task automatic t_simple;
      wr(qcp_pkg::A_DECODE, 32'h0);
      wr(qcp_pkg::A_COUNT, 32'h0);
      enc.pulse(0, 500, 500, 3);
      rd(qcp_pkg::A_COUNT, d);
      chk(d, 32'h3);
      enc.pulse(1, 500, 500, 2);
      rd(qcp_pkg::A_COUNT, d);
      chk(d, 32'h1);
   endtask

   task automatic t_match;
      int m0;
      wr(qcp_pkg::A_RESOL, 32'h0103);
      wr(qcp_pkg::A_COUNT, 32'h0);
      wr(qcp_pkg::A_TARGET, 32'h3);
      wr(qcp_pkg::A_STATUS, 32'h3);
      m0 = match_seen;
      enc.quad(0, 1'b1);
      chk(32'(match_seen - m0), 32'h1);
      rd(qcp_pkg::A_STATUS, d);
      chk(d & 32'h3, 32'h1);
      wr(qcp_pkg::A_STATUS, 32'h1);
      rd(qcp_pkg::A_STATUS, d);
      chk(d & 32'h3, 32'h0);
      wr(qcp_pkg::A_TARGET, 32'h1);
      enc.quad(0, 1'b0);
      chk(32'(match_seen - m0), 32'h2);
   endtask

   task automatic t_enables;
      wr(qcp_pkg::A_CNT_EN, 32'h2);
      rd(qcp_pkg::A_PM_EN, d);
      chk(d, 32'hC);
      wr(qcp_pkg::A_CNT_EN, 32'h0);
      wr(qcp_pkg::A_PM_EN, 32'h1);
      rd(qcp_pkg::A_CNT_EN, d);
      chk(d, 32'h0);
      wr(qcp_pkg::A_CNT_EN, 32'h1);
      wr(qcp_pkg::A_PM_EN, 32'h1);
      rd(qcp_pkg::A_CNT_EN, d);
      chk(d, 32'h0);
   endtask

   task automatic t_meter;
      wr(qcp_pkg::A_PM_EN, 32'h4);
      wr(qcp_pkg::A_OPTION, 32'h0);
      enc.pulse(2, 300, PER - 300, 4);
      rd(qcp_pkg::A_WIDTH + 12'h008, d);
      chk(d, 32'd30);
      rd(qcp_pkg::A_PERIOD + 12'h008, d);
      chk(d, 32'd100);
      rd(qcp_pkg::A_FREQ + 12'h008, d);
      chk(d, 32'(GATE / PER));
      wr(qcp_pkg::A_OPTION, 32'h1);
      enc.pulse(2, 300, PER - 300, 2);
      rd(qcp_pkg::A_WIDTH + 12'h008, d);
      chk(d, 32'd300);
      rd(qcp_pkg::A_PERIOD + 12'h008, d);
      chk(d, 32'd1000);
   endtask

   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_modes();
      t_decode();
      t_simple();
      t_match();
      t_enables();
      t_meter();
      summarize();
   end
endmodule
